// ---- rtl/srs_status.sv ----
// Status reporting structure with service request generation
`timescale 1ns/10ps
`default_nettype none

module srs_status
	import srs_pkg::*;
#(
	parameter int NUM_INPUTS = QUES_WIDTH
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	// Event sources, one-cycle pulses
	input  wire logic [ESR_WIDTH-1:0]  esr_event_set,
	input  wire logic                  unknown_cmd,
	input  wire logic                  ext_data_ready,
	// Event status register access
	input  wire logic                  esr_read,
	input  wire logic                  cls,
	output logic [ESR_WIDTH-1:0]       esr_value,
	// Event status enable mask
	input  wire logic                  ese_write,
	input  wire logic [ESR_WIDTH-1:0]  ese_wdata,
	output logic [ESR_WIDTH-1:0]       ese_value,
	// Digital inputs from pins
	input  wire logic [NUM_INPUTS-1:0] dig_in,
	output logic [NUM_INPUTS-1:0]      ques_cond,
	// Transition masks
	input  wire logic                  rtm_write,
	input  wire logic [NUM_INPUTS-1:0] rtm_wdata,
	output logic [NUM_INPUTS-1:0]      rising_transition_mask,
	input  wire logic                  ftm_write,
	input  wire logic [NUM_INPUTS-1:0] ftm_wdata,
	output logic [NUM_INPUTS-1:0]      falling_transition_mask,
	// Questionable enable mask and event register
	input  wire logic                  qen_write,
	input  wire logic [NUM_INPUTS-1:0] qen_wdata,
	output logic [NUM_INPUTS-1:0]      ques_enable,
	input  wire logic                  ques_read,
	output logic [NUM_INPUTS-1:0]      ques_event_value,
	// Status byte and service request enable
	input  wire logic                  msg_avail,
	input  wire logic                  sre_write,
	input  wire logic [STB_WIDTH-1:0]  sre_wdata,
	output logic [STB_WIDTH-1:0]       sre_value,
	input  wire logic                  serial_poll,
	output logic [STB_WIDTH-1:0]       status_byte,
	// Summaries
	output logic                       esr_summary,
	output logic                       ques_summary,
	output logic                       request_summary_bit,
	// Variant select: low parallel bus, high serial link
	input  wire logic                  serial_mode,
	// Open-drain service request line, driven low when enabled
	output logic                       srq_out,
	output logic                       srq_oe,
	// Serial request message stream
	output logic                       msg_valid,
	output logic [7:0]                 msg_byte,
	input  wire logic                  msg_ready
);

	// Storage
	logic [ESR_WIDTH-1:0]  esr;
	logic [NUM_INPUTS-1:0] pin_meta;
	logic [NUM_INPUTS-1:0] cond_prev;
	logic [NUM_INPUTS-1:0] ques_event;
	logic                  mss_prev;
	logic                  srq_pending;
	logic                  msg_pending;
	logic [STB_WIDTH-1:0]  msg_value;
	logic                  fmt_idle;

	// Event sources gathered into one set vector
	wire logic [ESR_WIDTH-1:0] esr_named =
		(ESR_WIDTH'(unknown_cmd) << ESR_UNKNOWN_CMD_BIT) |
		(ESR_WIDTH'(ext_data_ready) << ESR_EXT_DATA_BIT);
	wire logic [ESR_WIDTH-1:0] esr_set_all =
		esr_event_set | esr_named;

	// Set wins over a clear in the same cycle, so no event is lost
	wire logic                 esr_clear = esr_read || cls;
	wire logic [ESR_WIDTH-1:0] next_esr =
		(esr_clear ? ESR_RESET : esr) | esr_set_all;

	// Event summary from enabled bits
	wire logic esr_sum_w = |(esr & ese_value);

	// Edge detection on the synchronised condition
	wire logic [NUM_INPUTS-1:0] rise_w = ques_cond & ~cond_prev;
	wire logic [NUM_INPUTS-1:0] fall_w = ~ques_cond & cond_prev;
	wire logic [NUM_INPUTS-1:0] rise_hit =
		rise_w & rising_transition_mask;
	wire logic [NUM_INPUTS-1:0] fall_hit =
		fall_w & falling_transition_mask;
	wire logic [NUM_INPUTS-1:0] trans_hit = rise_hit | fall_hit;

	// Questionable event latch, set again wins over read or clear
	wire logic                  ques_clear = ques_read || cls;
	wire logic [NUM_INPUTS-1:0] next_ques_event =
		(ques_clear ? QUES_RESET[NUM_INPUTS-1:0] : ques_event) |
		trans_hit;

	// Questionable summary from enabled bits
	wire logic ques_sum_w = |(ques_event & ques_enable);

	// Status byte without its request bit
	wire logic [STB_WIDTH-1:0] stb_base =
		(STB_WIDTH'(ques_sum_w) << STB_QUES_BIT) |
		(STB_WIDTH'(msg_avail) << STB_MSG_BIT) |
		(STB_WIDTH'(esr_sum_w) << STB_ESR_BIT);

	// Request bit itself never enables a request
	wire logic [STB_WIDTH-1:0] sre_mask =
		sre_value & ~(STB_WIDTH'(1) << STB_RQS_BIT);
	wire logic mss_w = |(stb_base & sre_mask);

	wire logic [STB_WIDTH-1:0] next_status_byte =
		stb_base | (STB_WIDTH'(mss_w) << STB_RQS_BIT);

	// Only the rise of the summary requests; later bits are absorbed
	wire logic mss_rise = mss_w && !mss_prev;

	// Parallel request held until a poll or until the summary drops
	wire logic next_srq_pending =
		(mss_rise && !serial_mode) ? 1'b1 :
		(serial_poll || !mss_w) ? 1'b0 : srq_pending;

	// Serial message waits here while the formatter is busy
	wire logic msg_start = msg_pending && fmt_idle;
	wire logic next_msg_pending =
		(mss_rise && serial_mode) ? 1'b1 :
		msg_start ? 1'b0 : msg_pending;

	// Open drain: the line is only ever pulled low
	assign srq_out = 1'b0;
	assign srq_oe  = srq_pending;

	// Two-stage pin synchroniser; only the second stage is read
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta  <= QUES_RESET[NUM_INPUTS-1:0];
			ques_cond <= QUES_RESET[NUM_INPUTS-1:0];
		end else begin
			pin_meta  <= dig_in;
			ques_cond <= pin_meta;
		end
	end

	// Previous condition, seeded at reset so no false edge appears
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cond_prev <= QUES_RESET[NUM_INPUTS-1:0];
		end else begin
			cond_prev <= ques_cond;
		end
	end

	// Event status register and its read capture
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			esr       <= ESR_RESET;
			esr_value <= ESR_RESET;
		end else begin
			esr <= next_esr;
			if (esr_read) begin
				esr_value <= esr;
			end
		end
	end

	// Event enable mask, no state restricts the write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ese_value <= ESE_RESET;
		end else if (ese_write) begin
			ese_value <= ese_wdata;
		end
	end

	// Transition masks
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rising_transition_mask  <= QUES_RESET[NUM_INPUTS-1:0];
			falling_transition_mask <= QUES_RESET[NUM_INPUTS-1:0];
		end else begin
			if (rtm_write) begin
				rising_transition_mask <= rtm_wdata;
			end
			if (ftm_write) begin
				falling_transition_mask <= ftm_wdata;
			end
		end
	end

	// Questionable enable mask, writable at any time
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ques_enable <= QUES_RESET[NUM_INPUTS-1:0];
		end else if (qen_write) begin
			ques_enable <= qen_wdata;
		end
	end

	// Questionable event register and its read capture
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ques_event       <= QUES_RESET[NUM_INPUTS-1:0];
			ques_event_value <= QUES_RESET[NUM_INPUTS-1:0];
		end else begin
			ques_event <= next_ques_event;
			if (ques_read) begin
				ques_event_value <= ques_event;
			end
		end
	end

	// Service request enable mask
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sre_value <= SRE_RESET;
		end else if (sre_write) begin
			sre_value <= sre_wdata;
		end
	end

	// Status byte and summaries follow their sources one cycle later;
	// a poll or query only samples them and clears nothing upstream
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_byte         <= SRE_RESET;
			esr_summary         <= 1'b0;
			ques_summary        <= 1'b0;
			request_summary_bit <= 1'b0;
		end else begin
			status_byte         <= next_status_byte;
			esr_summary         <= esr_sum_w;
			ques_summary        <= ques_sum_w;
			request_summary_bit <= mss_w;
		end
	end

	// Request tracking for both variants
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mss_prev    <= 1'b0;
			srq_pending <= 1'b0;
			msg_pending <= 1'b0;
			msg_value   <= SRE_RESET;
		end else begin
			mss_prev    <= mss_w;
			srq_pending <= next_srq_pending;
			msg_pending <= next_msg_pending;
			if (mss_rise && serial_mode) begin
				msg_value <= next_status_byte;
			end
		end
	end

	// Serial message formatter; a stalled link only delays the message
	srs_msg_fmt u_fmt (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.start     (msg_start),
		.value     (msg_value),
		.idle      (fmt_idle),
		.out_valid (msg_valid),
		.out_byte  (msg_byte),
		.out_ready (msg_ready)
	);

endmodule
`default_nettype wire

// ---- pkg/srs_pkg.sv ----
// Shared constants for the status reporting and service request block
package srs_pkg;

	// Widths of the status structure
	localparam int ESR_WIDTH  = 8;
	localparam int QUES_WIDTH = 15;
	localparam int STB_WIDTH  = 8;

	// Event status bit positions
	localparam int ESR_UNKNOWN_CMD_BIT = 5;
	localparam int ESR_EXT_DATA_BIT    = 6;

	// Status byte bit positions
	localparam int STB_QUES_BIT = 3;
	localparam int STB_MSG_BIT  = 4;
	localparam int STB_ESR_BIT  = 5;
	localparam int STB_RQS_BIT  = 6;

	// Values after reset
	localparam logic [7:0]  ESR_RESET  = 8'h00;
	localparam logic [7:0]  ESE_RESET  = 8'h00;
	localparam logic [7:0]  SRE_RESET  = 8'h00;
	localparam logic [14:0] QUES_RESET = 15'h0000;

	// Characters of the serial request message
	localparam logic [7:0] CHR_S    = 8'h53;
	localparam logic [7:0] CHR_R    = 8'h52;
	localparam logic [7:0] CHR_M    = 8'h4d;
	localparam logic [7:0] CHR_LF   = 8'h0a;
	localparam logic [7:0] CHR_ZERO = 8'h30;

	// Message slots: three prefix, up to three digits, terminator
	localparam int MSG_SLOTS = 7;
	localparam logic [2:0] MSG_FIRST_DIGIT = 3'h3;

	// Decimal digit value to its character
	function automatic logic [7:0] srs_digit_char(input logic [7:0] d);
		srs_digit_char = CHR_ZERO + d;
	endfunction

endpackage

// ---- rtl/srs_msg_fmt.sv ----
// Serial request message formatter: prefix, decimal value, terminator
`timescale 1ns/10ps
`default_nettype none
module srs_msg_fmt
	import srs_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic [7:0] value,
	output logic            idle,
	output logic            out_valid,
	output logic [7:0]      out_byte,
	input  wire logic       out_ready
);

	typedef enum logic {SRS_ST_IDLE, SRS_ST_SEND} srs_fmt_state_t;

	srs_fmt_state_t state;
	logic [7:0]     msg [MSG_SLOTS];
	logic [2:0]     idx;
	logic [2:0]     last;

	// Decimal split of the captured value
	wire logic [7:0] hund = value / 8'd100;
	wire logic [7:0] tens = (value / 8'd10) % 8'd10;
	wire logic [7:0] ones = value % 8'd10;
	wire logic [1:0] ndig = (value >= 8'd100) ? 2'd3 :
		(value >= 8'd10) ? 2'd2 : 2'd1;

	// Leading zeros dropped, so the digits shift toward the prefix
	wire logic [7:0] dg_a = (ndig == 2'd3) ? srs_digit_char(hund) :
		(ndig == 2'd2) ? srs_digit_char(tens) : srs_digit_char(ones);
	wire logic [7:0] dg_b = (ndig == 2'd3) ? srs_digit_char(tens) :
		(ndig == 2'd2) ? srs_digit_char(ones) : CHR_LF;
	wire logic [7:0] dg_c = (ndig == 2'd3) ? srs_digit_char(ones) : CHR_LF;
	wire logic [2:0] next_last = MSG_FIRST_DIGIT + {1'b0, ndig};

	wire logic       take = out_valid && out_ready;

	assign idle      = (state == SRS_ST_IDLE);
	assign out_valid = (state == SRS_ST_SEND);
	assign out_byte  = msg[idx];

	// Message image is loaded once, then walked by the index
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= SRS_ST_IDLE;
			idx   <= 3'h0;
			last  <= 3'h0;
			for (int i = 0; i < MSG_SLOTS; i++) begin
				msg[i] <= 8'h00;
			end
		end else begin
			unique case (state)
				SRS_ST_IDLE: begin
					if (start) begin
						msg[0] <= CHR_S;
						msg[1] <= CHR_R;
						msg[2] <= CHR_M;
						msg[3] <= dg_a;
						msg[4] <= dg_b;
						msg[5] <= dg_c;
						msg[6] <= CHR_LF;
						idx    <= 3'h0;
						last   <= next_last;
						state  <= SRS_ST_SEND;
					end
				end
				SRS_ST_SEND: begin
					if (take && idx == last) begin
						state <= SRS_ST_IDLE;
					end else if (take) begin
						idx <= idx + 3'h1;
					end
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- tb/srs_status_props.sv ----
// Concurrent checks on the status block outputs
`timescale 1ns/10ps
`default_nettype none
module srs_status_chk
	import srs_pkg::*;
#(
	parameter int NUM_INPUTS = QUES_WIDTH
) (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [7:0] esr_event_set,
	input wire logic       unknown_cmd,
	input wire logic       ext_data_ready,
	input wire logic       esr_read,
	input wire logic       ese_write,
	input wire logic [7:0] ese_wdata,
	input wire logic [7:0] ese_value,
	input wire logic [7:0] status_byte,
	input wire logic       esr_summary,
	input wire logic       ques_summary,
	input wire logic       request_summary_bit,
	input wire logic       serial_mode,
	input wire logic       srq_oe,
	input wire logic       msg_valid,
	input wire logic [7:0] msg_byte,
	input wire logic       msg_ready
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Enabled events reach the summary exactly two edges on
	chk_cmd_summary: assert property (
		unknown_cmd && ese_value[5] && !ese_write |-> ##2 esr_summary)
		else $error("unknown command gave no summary");
	chk_ext_summary: assert property (
		ext_data_ready && ese_value[6] && !ese_write |-> ##2 esr_summary)
		else $error("external data gave no summary");
	// A read with no new set leaves nothing to summarise
	chk_read_clear: assert property (
		esr_read && !unknown_cmd && !ext_data_ready && esr_event_set == 8'h00
		|-> ##2 !esr_summary)
		else $error("event summary survived a read");
	// Summaries land in the status byte positions
	chk_stb_esr: assert property (
		status_byte[STB_ESR_BIT] == esr_summary)
		else $error("status bit 5 differs from event summary");
	chk_stb_ques: assert property (
		status_byte[STB_QUES_BIT] == ques_summary)
		else $error("status bit 3 differs from questionable summary");
	chk_ese_write: assert property (
		ese_write |=> ese_value == $past(ese_wdata))
		else $error("enable mask write lost");
	// Parallel variant pulls the line on a new request
	chk_srq_raise: assert property (
		$rose(request_summary_bit) && !serial_mode |-> ##[0:1] srq_oe)
		else $error("no service request line");
	chk_srq_drop: assert property (
		$fell(request_summary_bit) |-> ##[0:1] !srq_oe)
		else $error("request line held without summary");
	// A stalled byte must not move
	chk_msg_hold: assert property (
		msg_valid && !msg_ready |=> msg_valid && $stable(msg_byte))
		else $error("message byte dropped during stall");
endmodule

bind srs_status srs_status_chk #(.NUM_INPUTS(NUM_INPUTS)) u_chk (.*);
`default_nettype wire

// ---- tb/srs_host_model.sv ----
// Host model: stalling message sink and pulled-up request wire
`timescale 1ns/10ps
`default_nettype none
module srs_host_model
	import srs_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       msg_valid,
	input  wire logic [7:0] msg_byte,
	output logic            msg_ready,
	input  wire logic       srq_out,
	input  wire logic       srq_oe,
	output logic            srq_line,
	output logic [7:0]      got [8],
	output int              n_got
);
	// Pull-up wins unless the device enables its driver
	assign srq_line = srq_oe ? srq_out : 1'b1;
	// Ready every other cycle, so the sender must hold its byte
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			msg_ready <= 1'b0;
			n_got <= 0;
		end else begin
			msg_ready <= !msg_ready;
			if (msg_valid && msg_ready && n_got < 8) begin
				got[n_got[2:0]] <= msg_byte;
				n_got <= n_got + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the status reporting block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import srs_pkg::*;
	typedef struct packed {
		logic [14:0] rtm;
		logic [14:0] ftm;
		logic [14:0] from;
		logic [14:0] to;
		logic [14:0] exp;
	} srs_row_t;
	srs_row_t rows [4] = '{
		'{15'h0005, 15'h0006, 15'h0000, 15'h0007, 15'h0005},
		'{15'h0005, 15'h0006, 15'h0007, 15'h0000, 15'h0006},
		'{15'h0000, 15'h0000, 15'h0000, 15'h7fff, 15'h0000},
		'{15'h7fff, 15'h7fff, 15'h7fff, 15'h0000, 15'h7fff}};
	logic ref_clk = 0, rst_n = 0, unknown_cmd = 0, ext_data_ready = 0;
	logic esr_read = 0, cls = 0, ese_write = 0, rtm_write = 0, ftm_write = 0;
	logic qen_write = 0, ques_read = 0, msg_avail = 0, sre_write = 0;
	logic serial_poll = 0, serial_mode = 0;
	logic [7:0] esr_event_set = 0, ese_wdata = 0, sre_wdata = 0, v;
	logic [14:0] dig_in = 0, rtm_wdata = 0, ftm_wdata = 0, qen_wdata = 0;
	logic [7:0] esr_value, ese_value, sre_value, status_byte, msg_byte;
	logic [14:0] ques_cond, rising_transition_mask, falling_transition_mask;
	logic [14:0] ques_enable, ques_event_value;
	logic esr_summary, ques_summary, request_summary_bit, srq_out, srq_oe;
	logic msg_valid, msg_ready, srq_line;
	logic [7:0] got [8];
	int n_got, n_mismatch = 0, num_checks = 0;

	srs_status DUT (.*);
	srs_host_model u_host (.ref_clk(ref_clk), .rst_n(rst_n),
		.msg_valid(msg_valid), .msg_byte(msg_byte), .msg_ready(msg_ready),
		.srq_out(srq_out), .srq_oe(srq_oe), .srq_line(srq_line),
		.got(got), .n_got(n_got));

	initial forever #20 ref_clk = ~ref_clk;

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// One-cycle strobe launched and dropped on falling edges
	task automatic pulse(ref logic s);
		@(negedge ref_clk);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
	endtask
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard, well beyond the few hundred cycles needed
	initial begin
		#400000;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		tick(6);
		rst_n = 1;
		tick(2);
		// First read clears stale events, second sees the row's edges
		foreach (rows[i]) begin
			rtm_wdata = rows[i].rtm;
			ftm_wdata = rows[i].ftm;
			dig_in = rows[i].from;
			pulse(rtm_write);
			pulse(ftm_write);
			tick(6);
			pulse(ques_read);
			dig_in = rows[i].to;
			tick(6);
			pulse(ques_read);
			chk(ques_event_value, rows[i].exp);
			chk(ques_cond, rows[i].to);
		end
		$display("test transitions done");
		ese_wdata = 8'h60;
		sre_wdata = 8'h28;
		pulse(ese_write);
		pulse(sre_write);
		chk(ese_value, 8'h60);
		chk(sre_value, 8'h28);
		esr_event_set = 8'h01;
		pulse(unknown_cmd);
		esr_event_set = 8'h00;
		tick(5);
		chk(status_byte, 8'h60);
		chk(srq_line, 1'b0);
		pulse(serial_poll);
		tick(2);
		chk(status_byte, 8'h60);
		pulse(ext_data_ready);
		tick(5);
		chk(srq_oe, 1'b0);
		pulse(esr_read);
		chk(esr_value, 8'h61);
		tick(5);
		chk(status_byte, 8'h00);
		$display("test event path done");
		serial_mode = 1;
		qen_wdata = 15'h0001;
		rtm_wdata = 15'h0001;
		sre_wdata = 8'h08;
		pulse(qen_write);
		pulse(rtm_write);
		pulse(sre_write);
		pulse(cls);
		tick(3);
		dig_in = 15'h0001;
		for (int k = 0; k < 100 && n_got < 5; k++) tick(1);
		tick(20);
		v = 8'h00;
		for (int k = 3; k < n_got - 1; k++) v = v * 8'd10 + got[k] - 8'h30;
		chk({got[0], got[1], got[2]}, 24'h53_524d);
		chk(got[n_got - 1], 8'h0a);
		chk(v & 8'hbf, 8'h08);
		chk(status_byte[3], 1'b1);
		pulse(ques_read);
		chk(ques_event_value, 15'h0001);
		msg_avail = 1'b1;
		tick(3);
		chk({ques_summary, status_byte}, 9'h010);
		msg_avail = 1'b0;
		$display("test serial message done");
		rst_n = 0;
		tick(2);
		chk(srq_oe, 1'b0);
		rst_n = 1;
		tick(1);
		chk({status_byte, ese_value, sre_value}, 24'h00_0000);
		chk(rising_transition_mask | falling_transition_mask | ques_enable,
			15'h0000);
		chk({msg_valid, esr_summary, request_summary_bit}, 3'h0);
		$display("test reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
